// File: verilog/swid_device.sv
`timescale 1ns/1ps
`default_nettype none
`include "swid_defines.svh"
// How it works
// - Reset pulse answered by presence, then command
// - After rise, wait, then drive presence low
// - Master samples presence at fixed time
// - Slewed master lengthens reset by fall time
// - Master keeps reset low under 960 us
// - Master begins every slot except presence
// - Falling edge starts the slot timer
// - Write-one released before its low limit
// - Write-zero held low past its minimum
// - Recovery time between slots
// - Read zero drives low, one stays released
// - Master samples inside read window, waits slot
// - Idle high; long low resets devices
// - Standard speed at most 16.3 kbps
// - Command is eight write slots after presence
// - Command 33h sends all 64 identifier bits
// - Read identifier only with one slave
// - Family low, serial middle, CRC top byte
// - CRC x8+x5+x4+1, zero start, LSB first
// - Search sends true, complement, reads choice
// - Mismatch in search drops out until reset
// - Master resolves branch when both reads zero
// - Unsupported commands leave device silent
module swid_device
    import swid_pkg::*;
#(
    parameter logic [7:0]  FAMILY_CODE  = 8'h5a,             // Arbitrary value
    parameter logic [47:0] SERIAL_NUM   = 48'h0000_1234_abcd, // Arbitrary value
    parameter int unsigned RST_DET_CYC   = `SWID_DEV_RST_DET_US * `SWID_CLK_MHZ,
    parameter int unsigned PRES_LOW_CYC  = `SWID_PRES_LOW_US * `SWID_CLK_MHZ,
    parameter int unsigned PRES_WAIT_CYC = `SWID_PRES_WAIT_US * `SWID_CLK_MHZ,
    parameter int unsigned WR_SMP_CYC    = `SWID_WR_SAMPLE_US * `SWID_CLK_MHZ,
    parameter int unsigned RD_HOLD_CYC   = `SWID_RD_HOLD_US * `SWID_CLK_MHZ
) (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    swid_if.device          link,
    output var  logic [7:0] cmd_code,
    output var  logic       cmd_valid,
    output var  logic       search_active
);

    function automatic logic [7:0] crc8(input logic [55:0] d);
        logic [7:0] c;
        logic       fb;
        c  = 8'h00;
        fb = 1'b0;
        for (int i = 0; i < 56; i++) begin
            fb = c[0] ^ d[i];
            c  = {1'b0, c[7:1]};
            if (fb) begin
                c = c ^ `SWID_CRC_POLY_REFL;
            end
        end
        return c;
    endfunction : crc8

    function automatic logic is_rd(input swid_dstate_t s);
        return (s == DST_READ) || (s == DST_S_TRUE) || (s == DST_S_CMPL);
    endfunction : is_rd

    function automatic logic is_slot(input swid_dstate_t s);
        return is_rd(s) || (s == DST_CMD) || (s == DST_S_WR);
    endfunction : is_slot

    // Identifier fixed at elaboration
    localparam logic [63:0] ROM_ID = {crc8({SERIAL_NUM, FAMILY_CODE}),
                                      SERIAL_NUM, FAMILY_CODE};

    swid_dstate_t state_r;
    logic [31:0]  tm_r;
    logic [31:0]  low_cnt_r;
    logic         line_q_r;
    logic         slot_r;
    logic [5:0]   bit_r;
    logic [7:0]   cmd_r;
    logic         oe_r;
    logic         cmd_valid_r;
    logic         search_r;

    logic fall;
    logic rise;
    logic rst_end;
    logic tx_bit;
    logic slot_start;
    logic rd_end;
    logic wr_smp;
    logic pres_start;
    logic pres_end;
    logic [7:0] cmd_full;

    assign fall       = line_q_r && !link.line_in;
    assign rise       = !line_q_r && link.line_in;
    assign rst_end    = rise && (low_cnt_r >= RST_DET_CYC);
    assign tx_bit     = (state_r == DST_S_CMPL) ? !ROM_ID[bit_r] : ROM_ID[bit_r];
    assign slot_start = is_slot(state_r) && !slot_r && fall;
    assign rd_end     = slot_r && is_rd(state_r) && (tm_r == RD_HOLD_CYC - 1);
    assign wr_smp     = slot_r && !is_rd(state_r) && (tm_r == WR_SMP_CYC - 1);
    assign pres_start = (state_r == DST_PWAIT) && (tm_r == PRES_WAIT_CYC - 1);
    assign pres_end   = (state_r == DST_PLOW) && (tm_r == PRES_LOW_CYC - 1);
    assign cmd_full   = {link.line_in, cmd_r[7:1]};

    // Edge history of the line
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            line_q_r <= 1'b1;
        end else begin
            line_q_r <= link.line_in;
        end
    end

    // Low-time measurement, saturating so long holds cannot wrap
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            low_cnt_r <= 32'd0;
        end else if (link.line_in) begin
            low_cnt_r <= 32'd0;
        end else if (low_cnt_r < RST_DET_CYC) begin
            low_cnt_r <= low_cnt_r + 32'd1;
        end
    end

    // Slot activity flag
    always_ff @(posedge core_clk) begin
        if (!rst_n || rst_end) begin
            slot_r <= 1'b0;
        end else if (slot_start) begin
            slot_r <= 1'b1;
        end else if (rd_end || wr_smp) begin
            slot_r <= 1'b0;
        end
    end

    // Shared timer for presence phases and slot timing
    always_ff @(posedge core_clk) begin
        if (!rst_n || rst_end || slot_start || pres_start || pres_end) begin
            tm_r <= 32'd0;
        end else if (slot_r || state_r == DST_PWAIT || state_r == DST_PLOW) begin
            tm_r <= tm_r + 32'd1;
        end
    end

    // Protocol sequencing
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_r <= DST_IDLE;
            bit_r   <= 6'd0;
            cmd_r   <= 8'h00;
        end else if (rst_end) begin
            state_r <= DST_PWAIT;
            bit_r   <= 6'd0;
            cmd_r   <= 8'h00;
        end else if (pres_start) begin
            state_r <= DST_PLOW;
        end else if (pres_end) begin
            state_r <= DST_CMD;
        end else if (wr_smp) begin
            unique case (state_r)
                DST_CMD: begin
                    cmd_r <= cmd_full;
                    bit_r <= bit_r + 6'd1;
                    if (bit_r == 6'd7) begin
                        bit_r <= 6'd0;
                        if (cmd_full == `SWID_CMD_READ_ID) begin
                            state_r <= DST_READ;
                        end else if (cmd_full == `SWID_CMD_SEARCH) begin
                            state_r <= DST_S_TRUE;
                        end else begin
                            state_r <= DST_SILENT;
                        end
                    end
                end
                DST_S_WR: begin
                    if (link.line_in != ROM_ID[bit_r]) begin
                        state_r <= DST_SILENT;
                    end else if (bit_r == 6'd63) begin
                        state_r <= DST_SILENT;
                    end else begin
                        bit_r   <= bit_r + 6'd1;
                        state_r <= DST_S_TRUE;
                    end
                end
                default: begin
                    state_r <= state_r;
                end
            endcase
        end else if (rd_end) begin
            unique case (state_r)
                DST_READ: begin
                    bit_r <= bit_r + 6'd1;
                    if (bit_r == 6'd63) begin
                        state_r <= DST_SILENT;
                    end
                end
                DST_S_TRUE: begin
                    state_r <= DST_S_CMPL;
                end
                DST_S_CMPL: begin
                    state_r <= DST_S_WR;
                end
                default: begin
                    state_r <= state_r;
                end
            endcase
        end
    end

    // Open-drain pull-down; ones are sent by never driving
    always_ff @(posedge core_clk) begin
        if (!rst_n || rst_end) begin
            oe_r <= 1'b0;
        end else if (pres_start) begin
            oe_r <= 1'b1;
        end else if (pres_end) begin
            oe_r <= 1'b0;
        end else if (slot_start && is_rd(state_r) && !tx_bit) begin
            oe_r <= 1'b1;
        end else if (rd_end) begin
            oe_r <= 1'b0;
        end
    end

    // Completed command report
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cmd_valid_r <= 1'b0;
        end else begin
            cmd_valid_r <= wr_smp && (state_r == DST_CMD) && (bit_r == 6'd7);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            search_r <= 1'b0;
        end else begin
            search_r <= (state_r == DST_S_TRUE) || (state_r == DST_S_CMPL)
                        || (state_r == DST_S_WR);
        end
    end

    assign link.dev_out  = 1'b0;
    assign link.dev_oe   = oe_r;
    assign cmd_code      = cmd_r;
    assign cmd_valid     = cmd_valid_r;
    assign search_active = search_r;

endmodule : swid_device

`default_nettype wire

// File: verilog/swid_defines.svh
`ifndef SWID_DEFINES_SVH
`define SWID_DEFINES_SVH

// Core clock rate
`define SWID_CLK_MHZ          100

// Identifier layout
`define SWID_FAM_LSB          0
`define SWID_SER_LSB          8
`define SWID_CRC_LSB          56
`define SWID_CRC_POLY_REFL    8'h8c

// Command codes
`define SWID_CMD_READ_ID      8'h33
`define SWID_CMD_SEARCH       8'hf0
`define SWID_CMD_MATCH        8'h55
`define SWID_CMD_SKIP         8'hcc

// Device timing, microseconds
`define SWID_DEV_RST_DET_US   480
`define SWID_PRES_WAIT_US     30
`define SWID_PRES_LOW_US      120
`define SWID_WR_SAMPLE_US     30
`define SWID_RD_HOLD_US       30

// Master timing, microseconds
`define SWID_RSTL_US          480
`define SWID_RSTH_US          480
`define SWID_FALL_US          0
`define SWID_MSP_US           70
`define SWID_W0L_US           60
`define SWID_W1L_US           5
`define SWID_RL_US            2
`define SWID_MSR_US           13
`define SWID_SLOT_US          62
`define SWID_REC_US           3

`endif

// File: verilog/swid_pkg.sv
package swid_pkg;

    typedef enum logic [3:0] {
        DST_IDLE,
        DST_PWAIT,
        DST_PLOW,
        DST_CMD,
        DST_READ,
        DST_S_TRUE,
        DST_S_CMPL,
        DST_S_WR,
        DST_SILENT
    } swid_dstate_t;

    typedef enum logic [1:0] {
        MST_IDLE,
        MST_RST_LOW,
        MST_RST_HIGH,
        MST_SLOT
    } swid_mstate_t;

    typedef enum logic [1:0] {
        KIND_RESET,
        KIND_WRITE,
        KIND_READ,
        KIND_TRIPLET
    } swid_kind_t;

endpackage : swid_pkg

// File: verilog/swid_if.sv
`timescale 1ns/1ps
`default_nettype none

interface swid_if;
    logic dev_out;
    logic dev_oe;
    logic mst_out;
    logic mst_oe;
    logic line_in;

    // Pull-up resolves to high unless someone drives low
    assign line_in = !((dev_oe && !dev_out) || (mst_oe && !mst_out));

    modport device (input line_in, output dev_out, output dev_oe);
    modport master (input line_in, output mst_out, output mst_oe);
endinterface : swid_if

`default_nettype wire

// File: verilog/swid_master.sv
`timescale 1ns/1ps
`default_nettype none
`include "swid_defines.svh"
module swid_master
    import swid_pkg::*;
#(
    parameter int unsigned RSTL_CYC = (`SWID_RSTL_US + `SWID_FALL_US) * `SWID_CLK_MHZ,
    parameter int unsigned RSTH_CYC = `SWID_RSTH_US * `SWID_CLK_MHZ,
    parameter int unsigned MSP_CYC  = `SWID_MSP_US * `SWID_CLK_MHZ,
    parameter int unsigned W0L_CYC  = (`SWID_W0L_US + `SWID_FALL_US) * `SWID_CLK_MHZ,
    parameter int unsigned SLOT_CYC = (`SWID_SLOT_US + `SWID_REC_US) * `SWID_CLK_MHZ,
    parameter int unsigned W1L_CYC  = `SWID_W1L_US * `SWID_CLK_MHZ,
    parameter int unsigned RL_CYC   = `SWID_RL_US * `SWID_CLK_MHZ,
    parameter int unsigned MSR_CYC  = `SWID_MSR_US * `SWID_CLK_MHZ
) (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    swid_if.master          link,
    input  wire logic       req_valid,
    input  wire swid_kind_t req_kind,
    input  wire logic       req_bit,
    output var  logic       req_ready,
    output var  logic       rsp_valid,
    output var  logic [2:0] rsp_bits
);

    swid_mstate_t state_r;
    swid_kind_t   kind_r;
    logic [31:0]  tm_r;
    logic [1:0]   step_r;
    logic         dir_r;
    logic [2:0]   smp_r;
    logic         oe_r;
    logic         ready_r;
    logic         rsp_v_r;

    logic        slot_rd;
    logic        wbit;
    logic [31:0] low_len;

    // Branch choice: both reads zero means the caller's direction wins
    assign slot_rd = (kind_r == KIND_READ) || (kind_r == KIND_TRIPLET && step_r != 2'd2);
    assign wbit    = (kind_r == KIND_TRIPLET) ? ((!smp_r[0] && !smp_r[1]) ? dir_r : smp_r[0])
                                              : dir_r;
    assign low_len = slot_rd ? RL_CYC : (wbit ? W1L_CYC : W0L_CYC);

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_r <= MST_IDLE;
            kind_r  <= KIND_RESET;
            tm_r    <= 32'd0;
            step_r  <= 2'd0;
            dir_r   <= 1'b0;
            smp_r   <= 3'b000;
            oe_r    <= 1'b0;
            ready_r <= 1'b1;
            rsp_v_r <= 1'b0;
        end else begin
            rsp_v_r <= 1'b0;
            tm_r    <= tm_r + 32'd1;
            unique case (state_r)
                MST_IDLE: begin
                    tm_r <= 32'd0;
                    if (req_valid) begin
                        kind_r  <= req_kind;
                        dir_r   <= req_bit;
                        step_r  <= 2'd0;
                        smp_r   <= 3'b000;
                        oe_r    <= 1'b1;
                        ready_r <= 1'b0;
                        state_r <= (req_kind == KIND_RESET) ? MST_RST_LOW : MST_SLOT;
                    end
                end
                MST_RST_LOW: begin
                    // Fall time already folded into the low count
                    if (tm_r == RSTL_CYC - 1) begin
                        oe_r    <= 1'b0;
                        tm_r    <= 32'd0;
                        state_r <= MST_RST_HIGH;
                    end
                end
                MST_RST_HIGH: begin
                    if (tm_r == MSP_CYC - 1) begin
                        smp_r[0] <= !link.line_in;
                    end
                    if (tm_r == RSTH_CYC - 1) begin
                        state_r <= MST_IDLE;
                        ready_r <= 1'b1;
                        rsp_v_r <= 1'b1;
                    end
                end
                MST_SLOT: begin
                    if (tm_r == low_len - 1) begin
                        oe_r <= 1'b0;
                    end
                    if (slot_rd && tm_r == MSR_CYC - 1) begin
                        smp_r[step_r] <= link.line_in;
                    end
                    if (!slot_rd && kind_r == KIND_TRIPLET && tm_r == 32'd0) begin
                        smp_r[2] <= wbit;
                    end
                    // Full slot plus recovery keeps the rate under 16.3 kbps
                    if (tm_r == SLOT_CYC - 1) begin
                        tm_r <= 32'd0;
                        if (kind_r == KIND_TRIPLET && step_r != 2'd2) begin
                            step_r <= step_r + 2'd1;
                            oe_r   <= 1'b1;
                        end else begin
                            state_r <= MST_IDLE;
                            ready_r <= 1'b1;
                            rsp_v_r <= 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    assign link.mst_out = 1'b0;
    assign link.mst_oe  = oe_r;
    assign req_ready    = ready_r;
    assign rsp_valid    = rsp_v_r;
    assign rsp_bits     = smp_r;

endmodule : swid_master

`default_nettype wire

// File: tb/swid_link_props.sv
`timescale 1ns/1ps
`default_nettype none
module swid_link_props #(
    parameter int RST_DET_CYC   = 2000,
    parameter int PRES_LOW_CYC  = 1500,
    parameter int PRES_WAIT_CYC = 3000,
    parameter int HOLD_CYC      = 3000,
    parameter int RSTL_CYC      = 2000,
    parameter int W0L_CYC       = 5000,
    parameter int W1L_CYC       = 500,
    parameter int RL_CYC        = 200
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic dev_out,
    input wire logic dev_oe,
    input wire logic mst_out,
    input wire logic mst_oe,
    input wire logic line_in
);
    int   lo_cnt_r;
    int   hi_cnt_r;
    int   last_lo_r;
    int   dev_cnt_r;
    int   mst_cnt_r;
    logic pres_r;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    // Run lengths; long delays exceed what a delay range may span
    always_ff @(posedge core_clk) begin
        lo_cnt_r  <= (!rst_n || line_in) ? 0 : lo_cnt_r + 1;
        hi_cnt_r  <= (!rst_n || !line_in) ? 0 : hi_cnt_r + 1;
        dev_cnt_r <= (!rst_n || !dev_oe) ? 0 : dev_cnt_r + 1;
        mst_cnt_r <= (!rst_n || !mst_oe) ? 0 : mst_cnt_r + 1;
    end

    // Device pull while master is off can only be presence
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            last_lo_r <= 0;
            pres_r    <= 1'b0;
        end else begin
            if (line_in && lo_cnt_r != 0) begin
                last_lo_r <= lo_cnt_r;
            end
            if (dev_oe && dev_cnt_r == 0) begin
                pres_r <= !mst_oe;
            end
        end
    end

    a_dev_open_drain: assert property (dev_out == 1'b0)
        else $error("device drives the line high");
    a_mst_open_drain: assert property (mst_out == 1'b0)
        else $error("master drives the line high");
    a_pres_after_rst: assert property (
        $rose(dev_oe) && !mst_oe |-> last_lo_r >= RST_DET_CYC)
        else $error("presence without a reset pulse");
    a_pres_wait_time: assert property (
        $rose(dev_oe) && !mst_oe |-> hi_cnt_r inside {[PRES_WAIT_CYC-2:PRES_WAIT_CYC+2]})
        else $error("presence wait wrong");
    a_pres_low_time: assert property (
        $fell(dev_oe) && pres_r |-> dev_cnt_r == PRES_LOW_CYC)
        else $error("presence low length wrong");
    a_read_zero_start: assert property (
        $rose(dev_oe) && mst_oe |-> lo_cnt_r inside {[1:4]})
        else $error("read pull not started by the fall");
    a_read_zero_hold: assert property (
        $fell(dev_oe) && !pres_r |-> dev_cnt_r == HOLD_CYC)
        else $error("read pull length wrong");
    a_master_low_len: assert property (
        $fell(mst_oe) |-> mst_cnt_r inside {[RSTL_CYC-1:RSTL_CYC+1],
        [W0L_CYC-1:W0L_CYC+1], [W1L_CYC-1:W1L_CYC+1], [RL_CYC-1:RL_CYC+1]})
        else $error("master low pulse length wrong");
    a_slot_recovery: assert property (
        $rose(mst_oe) |-> last_lo_r == 0 || hi_cnt_r >= 100)
        else $error("slot started without recovery");

    c_presence: cover property ($fell(dev_oe) && pres_r);
    c_read_zero: cover property ($fell(dev_oe) && !pres_r);
    c_write_one: cover property ($fell(mst_oe) && mst_cnt_r == W1L_CYC);
endmodule : swid_link_props
`default_nettype wire

// File: tb/tb_single_wire_serial_id_slave.sv
`timescale 1ns/1ps
`default_nettype none
module tb_single_wire_serial_id_slave
    import swid_pkg::*;
;
    localparam logic [7:0]  FAM     = 8'ha7;              // Arbitrary value
    localparam logic [47:0] SER     = 48'h0123_4567_89ab; // Arbitrary value
    localparam int          RST_DET = 240;
    localparam int          PRES_LO = 150;
    localparam int          PRES_WT = 300;
    localparam int          HOLD    = 150;
    localparam int          W0L     = 200;
    localparam int          W1L     = 50;
    localparam int          RL      = 10;
    logic        core_clk;
    logic        rst_n;
    logic        req_valid;
    swid_kind_t  req_kind;
    logic        req_bit;
    logic        req_ready;
    logic        rsp_valid;
    logic [2:0]  rsp_bits;
    logic [7:0]  cmd_code;
    logic        cmd_valid;
    logic        search_active;
    logic [63:0] id_exp;
    logic [63:0] v;
    logic [2:0]  r;
    int          fails;
    int          samples_checked;
    int          cmd_cnt;

    swid_if link_if ();

    swid_device #(
        .FAMILY_CODE  (FAM),
        .SERIAL_NUM   (SER),
        .RST_DET_CYC   (RST_DET),
        .PRES_LOW_CYC  (PRES_LO),
        .PRES_WAIT_CYC (PRES_WT),
        .WR_SMP_CYC    (HOLD),
        .RD_HOLD_CYC   (HOLD)
    ) i_swid_device (
        .core_clk      (core_clk),
        .rst_n         (rst_n),
        .link          (link_if),
        .cmd_code      (cmd_code),
        .cmd_valid     (cmd_valid),
        .search_active (search_active)
    );

    // Shortened timings keep the run brief; device sample sits between W1L and W0L
    swid_master #(
        .RSTL_CYC (RST_DET),
        .RSTH_CYC (600),
        .MSP_CYC  (350),
        .W0L_CYC  (W0L),
        .SLOT_CYC (320),
        .W1L_CYC  (W1L),
        .RL_CYC   (RL),
        .MSR_CYC  (100)
    ) i_swid_master (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .link      (link_if),
        .req_valid (req_valid),
        .req_kind  (req_kind),
        .req_bit   (req_bit),
        .req_ready (req_ready),
        .rsp_valid (rsp_valid),
        .rsp_bits  (rsp_bits)
    );

    swid_link_props #(
        .RST_DET_CYC   (RST_DET),
        .PRES_LOW_CYC  (PRES_LO),
        .PRES_WAIT_CYC (PRES_WT),
        .HOLD_CYC      (HOLD),
        .RSTL_CYC      (RST_DET),
        .W0L_CYC       (W0L),
        .W1L_CYC       (W1L),
        .RL_CYC        (RL)
    ) i_props (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .dev_out  (link_if.dev_out),
        .dev_oe   (link_if.dev_oe),
        .mst_out  (link_if.mst_out),
        .mst_oe   (link_if.mst_oe),
        .line_in  (link_if.line_in)
    );

    always #5 core_clk = ~core_clk;

    always @(posedge core_clk) begin
        if (cmd_valid === 1'b1) begin
            cmd_cnt++;
        end
    end

    function automatic logic [7:0] crc8(input logic [55:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < 56; i++)
            c = (c >> 1) ^ ((c[0] ^ d[i]) ? 8'h8c : 8'h00);
        return c;
    endfunction : crc8

    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Entered just after an edge; holds the request until taken
    task automatic op(input swid_kind_t k, input logic b);
        int n;
        req_kind  = k;
        req_bit   = b;
        req_valid = 1'b1;
        for (n = 0; n < 8; n++) begin
            @(posedge core_clk);
            if (req_ready === 1'b1) break;
        end
        #1 req_valid = 1'b0;
        for (n = 0; n < 20000 && rsp_valid !== 1'b1; n++) begin
            @(posedge core_clk);
            #1;
        end
        chk("rsp_valid", 1, rsp_valid);
        r = rsp_bits;
    endtask : op

    task automatic line_reset();
        op(KIND_RESET, 1'b0);
        chk("presence", 1, r[0]);
    endtask : line_reset

    task automatic wr_byte(input logic [7:0] c);
        int n0;
        n0 = cmd_cnt;
        for (int i = 0; i < 8; i++) op(KIND_WRITE, c[i]);
        chk("cmd_code", c, cmd_code);
        chk("cmd_count", n0 + 1, cmd_cnt);
    endtask : wr_byte

    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test

    initial begin
        core_clk        = 1'b0;
        rst_n           = 1'b0;
        req_valid       = 1'b0;
        req_kind        = KIND_RESET;
        req_bit         = 1'b0;
        fails           = 0;
        samples_checked = 0;
        cmd_cnt         = 0;
        id_exp          = {crc8({SER, FAM}), SER, FAM};
        repeat (10) @(posedge core_clk);
        #1 rst_n = 1'b1;
        line_reset();
        wr_byte(8'h33);
        for (int i = 0; i < 64; i++) begin
            op(KIND_READ, 1'b1);
            v[i] = r[0];
        end
        chk("identifier", id_exp, v);
        $display("test read_id done");
        line_reset();
        for (int i = 0; i < 3; i++) op(KIND_WRITE, 1'b0);
        line_reset();
        wr_byte(8'hf0);
        chk("search_active", 1, search_active);
        for (int i = 0; i < 6; i++) begin
            op(KIND_TRIPLET, id_exp[i]);
            chk("triplet", {id_exp[i], !id_exp[i], id_exp[i]}, r);
        end
        op(KIND_TRIPLET, !id_exp[6]);
        chk("branch", {id_exp[6], !id_exp[6], id_exp[6]}, r);
        // Master never writes against a lone reader, so the wrong choice is sent by hand
        op(KIND_READ, 1'b1);
        chk("true_bit", id_exp[7], r[0]);
        op(KIND_READ, 1'b1);
        chk("cmpl_bit", !id_exp[7], r[0]);
        op(KIND_WRITE, !id_exp[7]);
        op(KIND_TRIPLET, 1'b0);
        chk("dropped", 3'b111, r);
        $display("test search done");
        for (int i = 0; i < 2; i++) begin
            line_reset();
            wr_byte(i ? 8'hcc : 8'h55);
            op(KIND_READ, 1'b1);
            chk("silent", 1, r[0]);
        end
        $display("test unsupported done");
        stop_test();
    end

    // Run needs about 45k cycles
    initial begin
        repeat (90000) @(posedge core_clk);
        fails++;
        stop_test();
    end
endmodule : tb_single_wire_serial_id_slave
`default_nettype wire
